// ### src/eir_pkg.sv
// Constants and types for the encoder, I/O routing and driver control block
// What this block does
// - Done-low selected: line 1 low, unless lower routing is on, and green lamp lit when idle within limits.
// - Idle means no pending commands and no active motion.
// - Opcode 187 selects done-low; accepted from either thread.
// - Enable-driver command restores a driver cut by command, kill or over-voltage.
// - Driver is enabled after reset without any command.
// - Opcode 227 enables the driver; thread 1 only.
// - Upper routing drives encoder A, B, index onto lines 4, 5, 6.
// - Bit set or clear on routed lines is refused.
// - Routing is refused while any target line is an output.
// - Mode 2 int ABZ, 3 ext ABZ, 4 off, 5 int AB, 6 ext AB.
// - Modes 3 and 6 only with a serial encoder port fitted.
// - Combined variant: routing also selects encoder reading into registers 200/201.
// - Combined variant: of routing and external-encoder select, the last executed one wins.
// - Opcode 192 carries mode, index state, reserved; last two must be zero.
// - Code 170 routes internal encoder to lower lines; optional per variant.
// - Thread 1 is held while motion runs, by default.
// - With multi-tasking on, thread 1 continues during motion.
// - Multi-tasking is independent of multi-threading.
// - Opcode 225 enables multi-tasking; thread 1 only.
// - Lower routing puts encoder A, B, index on lines 1, 2, 3.
// - Routing and bit-output conflicts raise command error and stop the program.
package eir_pkg;

	localparam int NUM_IO = 6;

	// Opcodes
	localparam logic [7:0] OPC_ROUTE_LOWER = 8'haa;
	localparam logic [7:0] OPC_DONE_LOW = 8'hbb;
	localparam logic [7:0] OPC_ROUTE_UPPER = 8'hc0;
	localparam logic [7:0] OPC_MT_ON = 8'he1;
	localparam logic [7:0] OPC_MT_OFF = 8'he2;
	localparam logic [7:0] OPC_DRV_ON = 8'he3;
	localparam logic [7:0] OPC_DRV_OFF = 8'he4;
	localparam logic [7:0] OPC_DONE_HIGH = 8'hfb;
	localparam logic [7:0] OPC_SEL_EXT_DEF = 8'hc1;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_IO_DIR = 8'h04;
	localparam logic [7:0] REG_BIT_SET = 8'h08;
	localparam logic [7:0] REG_BIT_CLR = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Control fields
	localparam int CTRL_LOWER_OK = 0;
	localparam int CTRL_COMBINED = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	// Status fields
	localparam int ST_ERR = 0;
	localparam int ST_DRV = 1;
	localparam int ST_MT = 2;
	localparam int ST_LOWER = 3;
	localparam int ST_DONE_LSB = 4;
	localparam int ST_MODE_LSB = 6;
	localparam int ST_ENC_READ = 9;
	localparam int ST_SSI = 10;

	// Routing modes
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_INT_ABZ = 3'h2,
		MODE_EXT_ABZ = 3'h3,
		MODE_DISABLE = 3'h4,
		MODE_INT_AB = 3'h5,
		MODE_EXT_AB = 3'h6
	} eir_mode_t;

	typedef enum logic [1:0] {
		DONE_NONE = 2'h0,
		DONE_HIGH = 2'h1,
		DONE_LOW = 2'h2
	} eir_done_t;

	localparam int LINE_A_LO = 0;
	localparam int LINE_A_HI = 3;
	localparam logic [5:0] MASK_LOWER = 6'h07;
	localparam logic [5:0] MASK_UPPER = 6'h38;

endpackage : eir_pkg

// ### src/eir_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module eir_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
		end else begin
			meta_q <= i_d;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_q <= '0;
		end else begin
			o_q <= meta_q;
		end
	end
endmodule : eir_sync

// ### src/eir_ctrl.sv
// Command decode, done indication, driver enable, encoder routing and multi-tasking
`timescale 1ns/1ps
module eir_ctrl #(
	parameter logic [7:0] P_OPC_SEL_EXT = eir_pkg::OPC_SEL_EXT_DEF
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	input wire logic I_CMD_VALID,
	input wire logic [7:0] I_CMD_OPCODE,
	input wire logic I_CMD_THREAD2,
	input wire logic [15:0] I_CMD_P0,
	input wire logic [15:0] I_CMD_P1,
	input wire logic [15:0] I_CMD_P2,
	output logic O_ACK,
	output logic O_CMD_ERR,
	output logic O_PROG_ABORT,
	input wire logic I_CMD_PENDING,
	input wire logic I_MOTION_ACTIVE,
	input wire logic I_IN_LIMITS,
	input wire logic I_KILL_MOTOR,
	input wire logic I_OVER_VOLTAGE,
	input wire logic I_SSI_FITTED,
	input wire logic I_ENC_A,
	input wire logic I_ENC_B,
	input wire logic I_ENC_Z,
	input wire logic I_EXT_A,
	input wire logic I_EXT_B,
	input wire logic I_EXT_Z,
	output logic [eir_pkg::NUM_IO-1:0] O_IO_OUT,
	output logic [eir_pkg::NUM_IO-1:0] O_IO_OE_N,
	output logic O_LED_GREEN,
	output logic O_DRIVER_EN,
	output logic O_MULTITASK,
	output logic O_THREAD1_HOLD,
	output logic O_ENC_READ_SEL,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA
);
	import eir_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [6:0] pins_s;
	logic enc_a_s, enc_b_s, enc_z_s, ext_a_s, ext_b_s, ext_z_s, ssi_s;

	eir_sync #(.W(7)) u_sync (
		.i_clk(I_SYS_CLK),
		.i_rst(I_RESET),
		.i_d({I_SSI_FITTED, I_EXT_Z, I_EXT_B, I_EXT_A, I_ENC_Z, I_ENC_B, I_ENC_A}),
		.o_q(pins_s)
	);

	assign {ssi_s, ext_z_s, ext_b_s, ext_a_s, enc_z_s, enc_b_s, enc_a_s} = pins_s;

	////////////////////////////////////////////////////////////////////////
	// State

	logic [1:0] ctrl_q;
	logic [NUM_IO-1:0] io_dir_q;
	logic [NUM_IO-1:0] bit_out_q;
	logic err_q;
	logic drv_en_q;
	logic mt_q;
	logic lower_q;
	logic enc_read_q;
	eir_done_t done_q;
	eir_mode_t mode_q;

	////////////////////////////////////////////////////////////////////////
	// Command decode

	logic is_t1;
	logic hit_done_low, hit_done_high, hit_drv_on, hit_drv_off, hit_mt_on, hit_mt_off;
	logic hit_upper, hit_lower, hit_sel;
	logic upper_ok, lower_ok, sel_ok;
	logic [15:0] mode_w;
	logic mode_ext, mode_route, mode_legal;
	logic cmd_known, cmd_accept, cmd_fail;

	assign is_t1 = !I_CMD_THREAD2;
	assign mode_w = I_CMD_P0;
	assign hit_done_low = I_CMD_VALID && I_CMD_OPCODE == OPC_DONE_LOW;
	assign hit_done_high = I_CMD_VALID && I_CMD_OPCODE == OPC_DONE_HIGH;
	assign hit_drv_on = I_CMD_VALID && I_CMD_OPCODE == OPC_DRV_ON;
	assign hit_drv_off = I_CMD_VALID && I_CMD_OPCODE == OPC_DRV_OFF;
	assign hit_mt_on = I_CMD_VALID && I_CMD_OPCODE == OPC_MT_ON;
	assign hit_mt_off = I_CMD_VALID && I_CMD_OPCODE == OPC_MT_OFF;
	assign hit_upper = I_CMD_VALID && I_CMD_OPCODE == OPC_ROUTE_UPPER;
	assign hit_lower = I_CMD_VALID && I_CMD_OPCODE == OPC_ROUTE_LOWER;
	assign hit_sel = I_CMD_VALID && I_CMD_OPCODE == P_OPC_SEL_EXT;

	// Mode word check
	assign mode_ext = mode_w == 16'(MODE_EXT_ABZ) || mode_w == 16'(MODE_EXT_AB);
	assign mode_route = mode_ext || mode_w == 16'(MODE_INT_ABZ) || mode_w == 16'(MODE_INT_AB);
	assign mode_legal = mode_route || mode_w == 16'(MODE_DISABLE);

	// Routing refused while a target line is an output
	assign upper_ok = is_t1 && mode_legal && I_CMD_P1 == 16'h0000 && I_CMD_P2 == 16'h0000
		&& !(mode_ext && !ssi_s)
		&& !(mode_route && |(io_dir_q & MASK_UPPER));
	assign lower_ok = ctrl_q[CTRL_LOWER_OK] && !(|(io_dir_q & MASK_LOWER));
	assign sel_ok = is_t1;

	assign cmd_known = hit_done_low || hit_done_high || hit_drv_on || hit_drv_off || hit_mt_on
		|| hit_mt_off || hit_upper || hit_lower || hit_sel;
	assign cmd_accept = hit_done_low || hit_done_high
		|| ((hit_drv_on || hit_drv_off || hit_mt_on || hit_mt_off) && is_t1)
		|| (hit_upper && upper_ok) || (hit_lower && lower_ok) || (hit_sel && sel_ok);
	assign cmd_fail = cmd_known && !cmd_accept;

	////////////////////////////////////////////////////////////////////////
	// Bit output access from the register port

	logic wr_set, wr_clr, bit_conflict, routed_hit;
	logic [NUM_IO-1:0] routed_mask;

	assign routed_mask = (lower_q ? MASK_LOWER : 6'h00)
		| ((mode_q != MODE_OFF && mode_q != MODE_DISABLE) ? MASK_UPPER : 6'h00);
	assign wr_set = I_WR && I_ADDR == REG_BIT_SET;
	assign wr_clr = I_WR && I_ADDR == REG_BIT_CLR;
	assign routed_hit = |(I_WDATA[NUM_IO-1:0] & routed_mask);
	assign bit_conflict = (wr_set || wr_clr) && routed_hit;

	////////////////////////////////////////////////////////////////////////
	// Answers

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_ACK <= 1'b0;
			O_CMD_ERR <= 1'b0;
			O_PROG_ABORT <= 1'b0;
		end else begin
			O_ACK <= cmd_accept;
			O_CMD_ERR <= cmd_fail || bit_conflict;
			O_PROG_ABORT <= cmd_fail || bit_conflict;
		end
	end

	// Sticky error, a new error wins over the clear
	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			err_q <= 1'b0;
		end else if (cmd_fail || bit_conflict) begin
			err_q <= 1'b1;
		end else if (I_WR && I_ADDR == REG_STATUS && I_WDATA[ST_ERR]) begin
			err_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Done indication mode

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			done_q <= DONE_NONE;
		end else if (hit_done_low) begin
			done_q <= DONE_LOW;
		end else if (hit_done_high) begin
			done_q <= DONE_HIGH;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Driver enable; any disable source wins over enable

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			drv_en_q <= 1'b1;
		end else if ((hit_drv_off && is_t1) || I_KILL_MOTOR || I_OVER_VOLTAGE) begin
			drv_en_q <= 1'b0;
		end else if (hit_drv_on && is_t1) begin
			drv_en_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Multi-tasking, unrelated to thread 2 activity

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			mt_q <= 1'b0;
		end else if (hit_mt_on && is_t1) begin
			mt_q <= 1'b1;
		end else if (hit_mt_off && is_t1) begin
			mt_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Encoder routing; in the combined variant the last executed of routing or select wins

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			mode_q <= MODE_OFF;
			enc_read_q <= 1'b0;
		end else if (hit_upper && upper_ok) begin
			mode_q <= eir_mode_t'(mode_w[2:0]);
			if (ctrl_q[CTRL_COMBINED]) begin
				enc_read_q <= mode_w != 16'(MODE_DISABLE);
			end
		end else if (hit_sel && sel_ok) begin
			enc_read_q <= 1'b1;
			if (ctrl_q[CTRL_COMBINED]) begin
				mode_q <= MODE_OFF;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			lower_q <= 1'b0;
		end else if (hit_lower && lower_ok) begin
			lower_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port writes

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			ctrl_q <= CTRL_RESET;
		end else if (I_WR && I_ADDR == REG_CTRL) begin
			ctrl_q <= I_WDATA[1:0];
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			io_dir_q <= '0;
		end else if (I_WR && I_ADDR == REG_IO_DIR) begin
			io_dir_q <= I_WDATA[NUM_IO-1:0];
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			bit_out_q <= '0;
		end else if (wr_set && !routed_hit) begin
			bit_out_q <= bit_out_q | I_WDATA[NUM_IO-1:0];
		end else if (wr_clr && !routed_hit) begin
			bit_out_q <= bit_out_q & ~I_WDATA[NUM_IO-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Done and line drive

	logic idle, done;
	logic [NUM_IO-1:0] line_val, line_drv;
	logic [NUM_IO-1:0] enc_src;
	logic upper_on, upper_z;

	assign idle = !I_CMD_PENDING && !I_MOTION_ACTIVE;
	assign done = idle && I_IN_LIMITS;
	assign upper_on = mode_q == MODE_INT_ABZ || mode_q == MODE_EXT_ABZ
		|| mode_q == MODE_INT_AB || mode_q == MODE_EXT_AB;
	assign upper_z = mode_q == MODE_INT_ABZ || mode_q == MODE_EXT_ABZ;
	// Placed on lines 4-6 so each line indexes its own bit
	assign enc_src = (mode_q == MODE_EXT_ABZ || mode_q == MODE_EXT_AB)
		? {ext_z_s, ext_b_s, ext_a_s, 3'h0} : {enc_z_s, enc_b_s, enc_a_s, 3'h0};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IO; gi++) begin : g_line
			always_comb begin
				line_val[gi] = bit_out_q[gi];
				line_drv[gi] = io_dir_q[gi];
				if (gi < LINE_A_HI && lower_q) begin
					line_val[gi] = (gi == 0) ? enc_a_s : (gi == 1) ? enc_b_s : enc_z_s;
					line_drv[gi] = 1'b1;
				end else if (gi >= LINE_A_HI && upper_on && (gi < NUM_IO - 1 || upper_z)) begin
					line_val[gi] = enc_src[gi];
					line_drv[gi] = 1'b1;
				end else if (gi == LINE_A_LO && done_q != DONE_NONE) begin
					line_val[gi] = (done_q == DONE_LOW) ? !done : done;
					line_drv[gi] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_IO_OUT <= '0;
			O_IO_OE_N <= '1;
		end else begin
			O_IO_OUT <= line_val;
			O_IO_OE_N <= ~line_drv;
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_LED_GREEN <= 1'b0;
			O_DRIVER_EN <= 1'b0;
			O_MULTITASK <= 1'b0;
			O_THREAD1_HOLD <= 1'b0;
			O_ENC_READ_SEL <= 1'b0;
		end else begin
			O_LED_GREEN <= done_q != DONE_NONE && done;
			O_DRIVER_EN <= drv_en_q;
			O_MULTITASK <= mt_q;
			O_THREAD1_HOLD <= I_MOTION_ACTIVE && !mt_q;
			O_ENC_READ_SEL <= enc_read_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port reads, one cycle later

	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (I_ADDR)
			REG_CTRL: rd_mux[1:0] = ctrl_q;
			REG_IO_DIR: rd_mux[NUM_IO-1:0] = io_dir_q;
			REG_BIT_SET: rd_mux[NUM_IO-1:0] = bit_out_q;
			REG_STATUS: begin
				rd_mux[ST_ERR] = err_q;
				rd_mux[ST_DRV] = drv_en_q;
				rd_mux[ST_MT] = mt_q;
				rd_mux[ST_LOWER] = lower_q;
				rd_mux[ST_DONE_LSB +: 2] = done_q;
				rd_mux[ST_MODE_LSB +: 3] = mode_q;
				rd_mux[ST_ENC_READ] = enc_read_q;
				rd_mux[ST_SSI] = ssi_s;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_RDATA <= 32'h0000_0000;
		end else if (I_RD) begin
			O_RDATA <= rd_mux;
		end else begin
			O_RDATA <= 32'h0000_0000;
		end
	end

endmodule : eir_ctrl

// ### bench/eir_ctrl_properties.sv
// Checker of command answers, driver, thread hold and read port timing
`timescale 1ns/1ps
module eir_ctrl_chk
	import eir_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	input wire logic I_CMD_VALID,
	input wire logic [7:0] I_CMD_OPCODE,
	input wire logic I_CMD_THREAD2,
	input wire logic [15:0] I_CMD_P1,
	input wire logic O_ACK,
	input wire logic O_CMD_ERR,
	input wire logic O_PROG_ABORT,
	input wire logic I_MOTION_ACTIVE,
	input wire logic I_KILL_MOTOR,
	input wire logic O_DRIVER_EN,
	input wire logic O_MULTITASK,
	input wire logic O_THREAD1_HOLD,
	input wire logic I_RD,
	input wire logic [31:0] O_RDATA
);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RESET);
	////////////////////////////////////////////////////////////////////////
	a_ack_err_excl: assert property (!(O_ACK && O_CMD_ERR))
		else $error("ack and error together");
	a_err_abort_pair: assert property (O_CMD_ERR == O_PROG_ABORT)
		else $error("abort not paired with error");
	a_ack_has_cause: assert property (O_ACK |-> $past(I_CMD_VALID))
		else $error("ack without command");
	a_thr2_drv_refused: assert property (I_CMD_VALID && I_CMD_THREAD2 && I_CMD_OPCODE == OPC_DRV_ON
		|=> O_CMD_ERR && !O_ACK) else $error("driver enable from thread 2 accepted");
	a_done_low_ack: assert property (I_CMD_VALID && I_CMD_OPCODE == OPC_DONE_LOW |=> O_ACK)
		else $error("done low not acknowledged");
	a_route_resv_err: assert property (I_CMD_VALID && I_CMD_OPCODE == OPC_ROUTE_UPPER
		&& I_CMD_P1 != 16'h0 |=> O_CMD_ERR) else $error("nonzero index state accepted");
	a_kill_drv_off: assert property (I_KILL_MOTOR |-> ##2 !O_DRIVER_EN)
		else $error("driver stays on under kill");
	a_mt_cmd_on: assert property (I_CMD_VALID && !I_CMD_THREAD2 && I_CMD_OPCODE == OPC_MT_ON
		|-> ##2 O_MULTITASK) else $error("multitasking not enabled");
	a_hold_default: assert property ((I_MOTION_ACTIVE && !O_MULTITASK) [*2] |-> O_THREAD1_HOLD)
		else $error("thread 1 not held during motion");
	a_mt_no_hold: assert property (O_MULTITASK |-> !O_THREAD1_HOLD)
		else $error("thread 1 held with multitasking");
	a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
		else $error("read data outside read cycle");
endmodule : eir_ctrl_chk

bind eir_ctrl eir_ctrl_chk u_chk (.*);

// ### bench/eir_host_model.sv
// Host model issuing addressed commands one pulse each
`timescale 1ns/1ps
module eir_host_model (
	input wire logic i_clk,
	output logic o_valid,
	output logic [7:0] o_op,
	output logic o_thr2,
	output logic [15:0] o_p0,
	output logic [15:0] o_p1,
	output logic [15:0] o_p2
);
	initial begin
		o_valid = 1'b0;
		o_op = 8'h00;
		o_thr2 = 1'b0;
		o_p0 = 16'h0;
		o_p1 = 16'h0;
		o_p2 = 16'h0;
	end
	// Whole command in one pulse; opcode and parameters scrambled once released, thread bit kept
	task automatic send(input logic [7:0] op, input logic thr2, input logic [15:0] p0, input logic [15:0] p1,
		input logic [15:0] p2);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_op <= op;
		o_thr2 <= thr2;
		o_p0 <= p0;
		o_p1 <= p1;
		o_p2 <= p2;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_op <= ~op;
		o_p0 <= ~p0;
		o_p1 <= ~p1;
		o_p2 <= 16'hffff;
	endtask : send
endmodule : eir_host_model

// ### bench/eir_ctrl_tb_top.sv
// Testbench for command decode, routing, driver and register port
`timescale 1ns/1ps
module eir_ctrl_tb_top;
	import eir_pkg::*;
	logic I_SYS_CLK, I_CMD_VALID, I_CMD_THREAD2, O_ACK, O_CMD_ERR, O_PROG_ABORT;
	logic [7:0] I_CMD_OPCODE;
	logic [15:0] I_CMD_P0, I_CMD_P1, I_CMD_P2;
	logic I_RESET = 1'b1, I_CMD_PENDING = 1'b0, I_MOTION_ACTIVE = 1'b0, I_IN_LIMITS = 1'b1;
	logic I_KILL_MOTOR = 1'b0, I_OVER_VOLTAGE = 1'b0, I_SSI_FITTED = 1'b0;
	logic I_ENC_A = 1'b0, I_ENC_B = 1'b1, I_ENC_Z = 1'b0, I_EXT_A = 1'b1, I_EXT_B = 1'b0, I_EXT_Z = 1'b1;
	logic [5:0] O_IO_OUT, O_IO_OE_N;
	logic O_LED_GREEN, O_DRIVER_EN, O_MULTITASK, O_THREAD1_HOLD, O_ENC_READ_SEL;
	logic [7:0] I_ADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0, O_RDATA, rv;
	logic I_WR = 1'b0, I_RD = 1'b0;
	logic [1:0] ans;
	int num_errors = 0;
	int total_checks = 0;

	eir_ctrl u_dut (.*);
	eir_host_model u_host (.i_clk(I_SYS_CLK), .o_valid(I_CMD_VALID), .o_op(I_CMD_OPCODE), .o_thr2(I_CMD_THREAD2),
		.o_p0(I_CMD_P0), .o_p1(I_CMD_P1), .o_p2(I_CMD_P2));

	initial begin
		I_SYS_CLK = 1'b0;
		forever #5 I_SYS_CLK = ~I_SYS_CLK;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge I_SYS_CLK);
		#1;
	endtask : tick
	// Answer sampled in the cycle after the command edge
	task automatic cmd(input logic [7:0] op, input logic t2, input logic [15:0] m, input logic [15:0] r = 16'h0,
		input logic [15:0] s = 16'h0);
		u_host.send(op, t2, m, r, s);
		#1 ans = {O_CMD_ERR, O_ACK};
	endtask : cmd
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_SYS_CLK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_SYS_CLK);
		I_WR <= 1'b0;
		I_WDATA <= ~d;
		#1 ans = {O_CMD_ERR, 1'b0};
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		@(posedge I_SYS_CLK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_SYS_CLK);
		I_RD <= 1'b0;
		#1 rv = O_RDATA;
	endtask : rreg
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge I_SYS_CLK);
		I_RESET <= 1'b0;
		tick(1);
		check(O_DRIVER_EN, 1'b1);
		check(O_IO_OE_N, 6'h3f);
		rreg(REG_CTRL);
		check(rv, 32'h1);
		rreg(8'h20);
		check(rv, 32'h0);
		cmd(OPC_DRV_ON, 1'b1, 16'h0);
		check(ans, 2'b10);
		cmd(OPC_DRV_OFF, 1'b0, 16'h0);
		tick(1);
		check(O_DRIVER_EN, 1'b0);
		cmd(OPC_DRV_ON, 1'b0, 16'h0);
		check(ans, 2'b01);
		tick(1);
		check(O_DRIVER_EN, 1'b1);
		for (int i = 0; i < 2; i++) begin
			@(posedge I_SYS_CLK);
			I_KILL_MOTOR <= (i == 0);
			I_OVER_VOLTAGE <= (i == 1);
			tick(2);
			@(posedge I_SYS_CLK);
			I_KILL_MOTOR <= 1'b0;
			I_OVER_VOLTAGE <= 1'b0;
			tick(2);
			check(O_DRIVER_EN, 1'b0);
			cmd(OPC_DRV_ON, 1'b0, 16'h0);
			tick(1);
			check(O_DRIVER_EN, 1'b1);
		end
		cmd(OPC_DONE_LOW, 1'b1, 16'h0);
		check(ans, 2'b01);
		tick(2);
		check({O_IO_OE_N[0], O_IO_OUT[0], O_LED_GREEN}, 3'b001);
		@(posedge I_SYS_CLK);
		I_CMD_PENDING <= 1'b1;
		tick(3);
		check({O_IO_OE_N[0], O_IO_OUT[0], O_LED_GREEN}, 3'b010);
		@(posedge I_SYS_CLK);
		I_CMD_PENDING <= 1'b0;
		I_MOTION_ACTIVE <= 1'b1;
		tick(3);
		check({O_IO_OUT[0], O_LED_GREEN, O_THREAD1_HOLD}, 3'b101);
		cmd(OPC_MT_ON, 1'b1, 16'h0);
		check(ans, 2'b10);
		cmd(OPC_MT_ON, 1'b0, 16'h0);
		tick(2);
		check({O_MULTITASK, O_THREAD1_HOLD}, 2'b10);
		// Done high polarity, motion still active
		cmd(OPC_DONE_HIGH, 1'b1, 16'h0);
		check(ans, 2'b01);
		tick(2);
		check({O_IO_OE_N[0], O_IO_OUT[0], O_LED_GREEN}, 3'b000);
		@(posedge I_SYS_CLK);
		I_MOTION_ACTIVE <= 1'b0;
		tick(2);
		check({O_IO_OE_N[0], O_IO_OUT[0], O_LED_GREEN}, 3'b011);
		for (int m = 1; m < 8; m++) begin
			cmd(OPC_ROUTE_UPPER, 1'b0, 16'(m));
			check(ans, (m == 2 || m == 4 || m == 5) ? 2'b01 : 2'b10);
		end
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h2, 16'h1);
		check(ans, 2'b10);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h2, 16'h0, 16'h1);
		check(ans, 2'b10);
		@(posedge I_SYS_CLK);
		I_SSI_FITTED <= 1'b1;
		tick(3);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h3);
		tick(5);
		check({O_IO_OE_N[5:3], O_IO_OUT[5:3]}, 6'b000101);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h2);
		tick(2);
		check(O_IO_OUT[5:3], 3'b010);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h5);
		tick(2);
		check({O_IO_OE_N[5:3], O_IO_OUT[4:3]}, 5'b10010);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h6);
		tick(2);
		check({O_IO_OE_N[5:3], O_IO_OUT[4:3]}, 5'b10001);
		wreg(REG_BIT_SET, 32'h20);
		check(ans, 2'b10);
		wreg(REG_BIT_CLR, 32'h08);
		check(ans, 2'b10);
		rreg(REG_BIT_SET);
		check(rv, 32'h0);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h4);
		tick(2);
		check(O_IO_OE_N[5:3], 3'h7);
		wreg(REG_BIT_SET, 32'h20);
		check(ans, 2'b00);
		rreg(REG_BIT_SET);
		check(rv, 32'h20);
		wreg(REG_IO_DIR, 32'h10);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h2);
		check(ans, 2'b10);
		wreg(REG_IO_DIR, 32'h0);
		cmd(OPC_ROUTE_LOWER, 1'b0, 16'h0);
		check(ans, 2'b01);
		tick(2);
		check({O_IO_OE_N[2:0], O_IO_OUT[2:0]}, 6'b000010);
		wreg(REG_CTRL, 32'h3);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h2);
		tick(2);
		check({O_ENC_READ_SEL, O_IO_OE_N[5:3]}, 4'b1000);
		cmd(OPC_SEL_EXT_DEF, 1'b0, 16'h0);
		tick(2);
		check({O_ENC_READ_SEL, O_IO_OE_N[5:3]}, 4'b1111);
		cmd(OPC_ROUTE_UPPER, 1'b0, 16'h4);
		tick(2);
		check(O_ENC_READ_SEL, 1'b0);
		wreg(REG_CTRL, 32'h0);
		cmd(OPC_ROUTE_LOWER, 1'b0, 16'h0);
		check(ans, 2'b10);
		cmd(OPC_MT_OFF, 1'b1, 16'h0);
		check(ans, 2'b10);
		rreg(REG_STATUS);
		check(rv[2:0], 3'b111);
		cmd(OPC_MT_OFF, 1'b0, 16'h0);
		tick(2);
		check(O_MULTITASK, 1'b0);
		summarize();
	end
endmodule : eir_ctrl_tb_top
